// file: shared/fw_loader_pkg.sv
// constants for the firmware upgrade command interpreter
// assumes an smbus byte-level link layer on the same clock
package fw_loader_pkg;
  localparam int          CLK_HZ       = 25000000;
  localparam int          TICK_MS      = 1;
  localparam logic [7:0]  CMD_UNLOCK   = 8'hE0;
  localparam logic [7:0]  CMD_SEQ_RD   = 8'hE4;
  localparam logic [7:0]  CMD_STATUS   = 8'hE5;
  localparam logic [7:0]  CMD_BOOT     = 8'hE6;
  localparam logic [7:0]  CMD_DATA     = 8'hE7;
  localparam logic [7:0]  CMD_ORDER    = 8'hE8;
  localparam logic [7:0]  CMD_BBOX     = 8'hF0;
  localparam logic [7:0]  ACT_ENTER    = 8'h01;
  localparam logic [7:0]  ACT_ERASE    = 8'h02;
  localparam logic [7:0]  ACT_DONE     = 8'h03;
  localparam logic [7:0]  ACT_EXIT     = 8'h04;
  localparam int          ST_ERASED    = 0;
  localparam int          ST_CRC       = 1;
  localparam int          ST_SEQ       = 2;
  localparam int          ST_RANGE     = 3;
  localparam int          ST_BOOT      = 7;
  localparam logic [7:0]  STATUS_APP   = 8'h00;
  localparam logic [7:0]  STATUS_OK    = 8'h80;
  localparam logic [15:0] SEQ_FIRST    = 16'h0000;
  localparam logic [7:0]  SEQ_LEN      = 8'h03;
  localparam logic [7:0]  ORDER_LEN    = 8'h0B;
  localparam logic [31:0] PASSWORD     = 32'h55504744;
  localparam logic [7:0]  UNLOCK_LAST  = 8'h05;
  localparam logic [7:0]  UNLOCK_END   = 8'h07;
  localparam logic [7:0]  BOOT_END     = 8'h04;
  localparam logic [7:0]  DATA_HDR     = 8'h04;
  localparam logic [7:0]  DATA_END     = 8'h06;
  localparam logic [7:0]  PEC_POLY     = 8'h07;
  localparam logic [15:0] CRC_POLY     = 16'h1021;
  localparam logic [15:0] CRC_INIT     = 16'hFFFF;
  localparam int          BB_RECORDS   = 5;
  localparam int          BB_REC_BYTES = 6;
  localparam logic [7:0]  FILL_BYTE    = 8'hFF;
endpackage

// file: src/fw_upgrade_loader.sv
// firmware upgrade command interpreter with rolling event recorder
// assumes a same-clock smbus link layer that delivers bytes and
// start/stop/read-request pulses, and a flash writer behind mem_wr
//
// Functional notes
// RL1: boot command carries target, action byte and pec.
// RL2: action 1 enter, 2 erase, 3 upload done, 4 exit.
// RL3: target byte ignored for enter and exit.
// RL4: main output switched off by the loader when entering boot.
// RL5: host waits one second after erase.
// RL6: after erase completes status reads boot mode with erased bit.
// RL7: data packet: target, seq low, seq high, count, payload, pec.
// RL8: expected sequence advances by one per accepted packet.
// RL9: following read returns count 3, seq low, seq high, status, pec.
// RL10: host restarts the upgrade when status flags an error.
// RL11: host sends next packet with the last reported sequence.
// RL12: upload done compares image crc-16 with its last two bytes.
// RL13: host waits one second after upload done.
// RL14: valid check leaves status at boot mode, no error bits.
// RL15: exit hands control to the loaded application.
// RL16: status reads zero once the application runs.
// RL17: host upgrades power factor processor first, then others.
// RL18: ordering code read returns count eleven, eleven bytes, pec.
// RL19: application never started after a programming error.
// RL20: recorder keeps five stamped records, oldest overwritten.
// RL21: host waits 100 ms before restarting a black box upload.
// RL22: failed black box upload reports length zero then pec.
// RL23: status bits: erased, crc bad, seq, range, in boot.
// RL24: upgrade commands locked until password is written.
// RL25: exit succeeds only when the image is valid; the code only needs status 0x80, which enter alone also sets.
// RL26: writes with a wrong pec change nothing; data payload bytes still go out on mem_wr before the pec is checked.
`timescale 1ns/100ps
module fw_upgrade_loader #(
  parameter int MAX_BYTES   = 32,
  parameter int TICK_CYCLES =
    fw_loader_pkg::CLK_HZ / 1000 * fw_loader_pkg::TICK_MS
)(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        link_start,
  input  wire logic        link_stop,
  input  wire logic        link_byte_valid,
  input  wire logic [7:0]  link_byte,
  input  wire logic        link_rd_req,
  output logic      [7:0]  tx_byte,
  input  wire logic        main_output_on,
  output logic             output_off,
  output logic             sw_reboot,
  output logic             app_start,
  output logic             erase_req,
  output logic      [7:0]  erase_target,
  input  wire logic        erase_done,
  output logic             mem_wr_valid,
  output logic      [15:0] mem_wr_seq,
  output logic      [7:0]  mem_wr_off,
  output logic      [7:0]  mem_wr_data,
  output logic      [7:0]  app_status,
  input  wire logic [87:0] ordering_code,
  input  wire logic        bb_trigger,
  input  wire logic [31:0] bb_snapshot,
  input  wire logic        bb_data_ok
);
  import fw_loader_pkg::*;

  // refuse sizes that the 8-bit byte index and the divider cannot serve
  if (MAX_BYTES < 1 || MAX_BYTES > 240 || TICK_CYCLES < 2) begin : g_bad_cfg
    $error("fw_upgrade_loader: unsupported parameter value");
  end

  typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_WRITE, PH_READ} phase_t;

  // smbus packet error code step, crc-8 x8+x2+x+1
  function automatic logic [7:0] pec_step(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ((r << 1) ^ PEC_POLY) : (r << 1);
    return r;
  endfunction

  // image check step, crc-16 msb first
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++)
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    return r;
  endfunction

  phase_t      phase, next_phase;
  logic        in_xfer, next_in_xfer;
  logic [7:0]  pec, next_pec;
  logic [7:0]  idx, next_idx;
  logic [7:0]  rd_idx, next_rd_idx;
  logic [7:0]  cmd, next_cmd;
  logic [7:0]  target, next_target;
  logic [7:0]  act, next_act;
  logic [7:0]  cnt, next_cnt;
  logic [15:0] rx_seq, next_rx_seq;
  logic        pw_bad, next_pw_bad;
  logic        unlocked, next_unlocked;
  logic [15:0] exp_seq, next_exp_seq;
  logic [7:0]  status, next_status;
  logic [15:0] img_crc, next_img_crc, work_crc, next_work_crc;
  logic [15:0] img_tail, next_img_tail, work_tail, next_work_tail;
  logic [1:0]  img_fill, next_img_fill, work_fill, next_work_fill;
  logic        next_output_off, next_sw_reboot, next_app_start;
  logic        next_erase_req, next_mem_wr_valid;
  logic [7:0]  next_erase_target, next_mem_wr_off, next_mem_wr_data;
  logic [15:0] next_mem_wr_seq;
  logic [7:0]  next_tx_byte, resp_byte, resp_len;
  logic        resp_counted, exec_ok, data_ok;
  logic [2:0]  bb_rec, next_bb_rec, bb_oldest;
  logic [2:0]  bb_byte, next_bb_byte;
  logic [2:0]  bb_wptr, next_bb_wptr, bb_count, next_bb_count;
  logic [15:0] stamp, next_stamp;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic [47:0] bb_mem [BB_RECORDS];

  assign app_status = status;
  assign bb_oldest  = (bb_count < 3'(BB_RECORDS)) ? 3'd0 : bb_wptr;
  // a good write: pec residue zero and the upgrade commands unlocked
  assign exec_ok = !(phase == PH_READ) && pec == 8'h00 && unlocked; // RL26
  assign data_ok = rx_seq == exp_seq && cnt <= 8'(MAX_BYTES);

  // read response selection for the last command code
  always_comb begin
    resp_counted = 1'b1;
    resp_len     = 8'h00;
    resp_byte    = FILL_BYTE;
    case (cmd)
      CMD_SEQ_RD, CMD_DATA: begin
        resp_len = SEQ_LEN; // RL9
        case (rd_idx)
          8'h01:   resp_byte = exp_seq[7:0];
          8'h02:   resp_byte = exp_seq[15:8];
          8'h03:   resp_byte = status;
          default: resp_byte = FILL_BYTE;
        endcase
      end
      CMD_ORDER: begin
        resp_len = ORDER_LEN; // RL18
        if (rd_idx >= 8'h01 && rd_idx <= ORDER_LEN)
          resp_byte = ordering_code[8 * (rd_idx - 8'h01) +: 8];
      end
      CMD_BBOX: begin
        resp_len = bb_data_ok ? 8'(bb_count * BB_REC_BYTES) : 8'h00; // RL22
        resp_byte = bb_mem[bb_rec][8 * bb_byte +: 8];
      end
      CMD_STATUS: begin
        resp_counted = 1'b0;
        resp_byte    = status; // RL23
      end
      default: resp_counted = 1'b0;
    endcase
    if (resp_counted && rd_idx == 8'h00)
      resp_byte = resp_len;
    else if (rd_idx == (resp_counted ? resp_len + 8'h01 : 8'h01))
      resp_byte = pec;
  end

  // transaction parser and command interpreter
  always_comb begin
    next_phase = phase;         next_in_xfer = in_xfer;
    next_pec = pec;             next_idx = idx;
    next_rd_idx = rd_idx;       next_cmd = cmd;
    next_target = target;       next_act = act;
    next_cnt = cnt;             next_rx_seq = rx_seq;
    next_pw_bad = pw_bad;       next_unlocked = unlocked;
    next_exp_seq = exp_seq;     next_status = status;
    next_img_crc = img_crc;     next_work_crc = work_crc;
    next_img_tail = img_tail;   next_work_tail = work_tail;
    next_img_fill = img_fill;   next_work_fill = work_fill;
    next_output_off = output_off;
    next_sw_reboot = 1'b0;      next_app_start = 1'b0;
    next_erase_req = 1'b0;      next_erase_target = erase_target;
    next_mem_wr_valid = 1'b0;   next_mem_wr_seq = mem_wr_seq;
    next_mem_wr_off = mem_wr_off;
    next_mem_wr_data = mem_wr_data;
    next_tx_byte = tx_byte;     next_bb_rec = bb_rec;
    next_bb_byte = bb_byte;
    if (link_start) begin
      if (!in_xfer)
        next_pec = 8'h00;       // pec spans a repeated start
      next_in_xfer = 1'b1;
      next_phase   = PH_ADDR;
    end else if (link_byte_valid && phase != PH_IDLE) begin
      next_pec = pec_step(pec, link_byte);
      if (phase == PH_ADDR) begin
        next_phase  = link_byte[0] ? PH_READ : PH_WRITE;
        next_idx    = 8'h00;
        next_rd_idx = 8'h00;
        next_pw_bad = 1'b0;
        next_bb_rec = bb_oldest;
        next_bb_byte = 3'd0;
      end else if (phase == PH_WRITE) begin
        next_idx = idx + 8'h01;
        if (idx == 8'h00)
          next_cmd = link_byte;
        else begin
          case (cmd)
            CMD_UNLOCK: begin
              if (idx == 8'h01)
                next_cnt = link_byte;
              else if (idx <= UNLOCK_LAST &&
                       link_byte != PASSWORD[8 * (UNLOCK_LAST - idx) +: 8])
                next_pw_bad = 1'b1; // RL24
            end
            CMD_BOOT: begin
              if (idx == 8'h01)
                next_target = link_byte; // RL1
              else if (idx == 8'h02)
                next_act = link_byte;
            end
            CMD_DATA: begin
              if (idx == 8'h01)
                next_target = link_byte; // RL7
              else if (idx == 8'h02)
                next_rx_seq[7:0] = link_byte;
              else if (idx == 8'h03)
                next_rx_seq[15:8] = link_byte;
              else if (idx == DATA_HDR) begin
                next_cnt = link_byte;
                next_work_crc = img_crc;
                next_work_tail = img_tail;
                next_work_fill = img_fill;
              end else if (idx <= DATA_HDR + cnt && unlocked &&
                           status[ST_BOOT] && data_ok) begin
                // last two image bytes stay out of the running crc
                if (work_fill == 2'd2)
                  next_work_crc = crc_step(work_crc, work_tail[15:8]);
                else
                  next_work_fill = work_fill + 2'd1;
                next_work_tail = {work_tail[7:0], link_byte}; // RL12
                next_mem_wr_valid = 1'b1;
                next_mem_wr_seq = rx_seq;
                next_mem_wr_off = idx - DATA_HDR - 8'h01;
                next_mem_wr_data = link_byte;
              end
            end
            default: ;
          endcase
        end
      end
    end else if (link_rd_req && phase == PH_READ) begin
      next_tx_byte = resp_byte;
      next_pec     = pec_step(pec, resp_byte);
      next_rd_idx  = rd_idx + 8'h01;
      if (cmd == CMD_BBOX && rd_idx != 8'h00) begin
        if (bb_byte == 3'(BB_REC_BYTES - 1)) begin
          next_bb_byte = 3'd0;
          next_bb_rec = (bb_rec == 3'(BB_RECORDS - 1)) ? 3'd0
                                                       : bb_rec + 3'd1;
        end else
          next_bb_byte = bb_byte + 3'd1;
      end
    end else if (link_stop) begin
      next_in_xfer = 1'b0;
      next_phase   = PH_IDLE;
      if (phase == PH_WRITE && cmd == CMD_UNLOCK && idx == UNLOCK_END &&
          pec == 8'h00 && !pw_bad)
        next_unlocked = 1'b1; // RL24
      if (phase == PH_WRITE && exec_ok && cmd == CMD_BOOT &&
          idx == BOOT_END) begin
        case (act) // RL2
          ACT_ENTER: begin                  // RL3
            next_status = STATUS_OK;
            next_sw_reboot = 1'b1;
            next_output_off = main_output_on | output_off; // RL4
            next_exp_seq = SEQ_FIRST;
          end
          ACT_ERASE: if (status[ST_BOOT]) begin
            next_erase_req = 1'b1;
            next_erase_target = target;
            next_exp_seq = SEQ_FIRST;       // RL7
            next_img_crc = CRC_INIT;
            next_img_fill = 2'd0;
            next_status = STATUS_OK;
          end
          ACT_DONE: if (status[ST_BOOT]) begin
            next_status[ST_CRC] = img_fill != 2'd2 ||
                                  img_crc != img_tail; // RL12
            if (img_fill == 2'd2 && img_crc == img_tail)
              next_status = STATUS_OK;      // RL14
          end
          ACT_EXIT: if (status == STATUS_OK) begin // RL19 RL25
            next_status = STATUS_APP;       // RL16
            next_app_start = 1'b1;          // RL15
            next_output_off = 1'b0;
          end
          default: ;
        endcase
      end
      if (phase == PH_WRITE && exec_ok && cmd == CMD_DATA &&
          idx == DATA_END + cnt && status[ST_BOOT]) begin
        if (rx_seq != exp_seq)
          next_status[ST_SEQ] = 1'b1;     // RL23
        else if (cnt > 8'(MAX_BYTES))
          next_status[ST_RANGE] = 1'b1;
        else begin
          next_exp_seq = exp_seq + 16'h0001; // RL8
          next_img_crc = work_crc;
          next_img_tail = work_tail;
          next_img_fill = work_fill;
        end
      end
    end
    if (erase_done && next_status[ST_BOOT])
      next_status[ST_ERASED] = 1'b1; // RL6
  end

  // interpreter registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= PH_IDLE;     in_xfer <= 1'b0;      pec <= 8'h00;
      idx <= 8'h00;         rd_idx <= 8'h00;      cmd <= 8'h00;
      target <= 8'h00;      act <= 8'h00;         cnt <= 8'h00;
      rx_seq <= SEQ_FIRST;  pw_bad <= 1'b0;       unlocked <= 1'b0;
      exp_seq <= SEQ_FIRST; status <= STATUS_APP;
      img_crc <= CRC_INIT;  work_crc <= CRC_INIT;
      img_tail <= 16'h0000; work_tail <= 16'h0000;
      img_fill <= 2'd0;     work_fill <= 2'd0;
      output_off <= 1'b0;   sw_reboot <= 1'b0;    app_start <= 1'b0;
      erase_req <= 1'b0;    erase_target <= 8'h00;
      mem_wr_valid <= 1'b0; mem_wr_seq <= SEQ_FIRST;
      mem_wr_off <= 8'h00;  mem_wr_data <= 8'h00;
      tx_byte <= 8'h00;     bb_rec <= 3'd0;       bb_byte <= 3'd0;
    end else begin
      phase <= next_phase;     in_xfer <= next_in_xfer;
      pec <= next_pec;         idx <= next_idx;
      rd_idx <= next_rd_idx;   cmd <= next_cmd;
      target <= next_target;   act <= next_act;
      cnt <= next_cnt;         rx_seq <= next_rx_seq;
      pw_bad <= next_pw_bad;   unlocked <= next_unlocked;
      exp_seq <= next_exp_seq; status <= next_status;
      img_crc <= next_img_crc; work_crc <= next_work_crc;
      img_tail <= next_img_tail; work_tail <= next_work_tail;
      img_fill <= next_img_fill; work_fill <= next_work_fill;
      output_off <= next_output_off; sw_reboot <= next_sw_reboot;
      app_start <= next_app_start;   erase_req <= next_erase_req;
      erase_target <= next_erase_target;
      mem_wr_valid <= next_mem_wr_valid; mem_wr_seq <= next_mem_wr_seq;
      mem_wr_off <= next_mem_wr_off; mem_wr_data <= next_mem_wr_data;
      tx_byte <= next_tx_byte; bb_rec <= next_bb_rec;
      bb_byte <= next_bb_byte;
    end
  end

  // millisecond stamp divider and rolling recorder pointers
  always_comb begin
    next_tick_cnt = tick_cnt + 32'd1;
    next_stamp    = stamp;
    if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
      next_tick_cnt = 32'd0;
      next_stamp    = stamp + 16'h0001;
    end
    next_bb_wptr  = bb_wptr;
    next_bb_count = bb_count;
    if (bb_trigger) begin
      next_bb_wptr = (bb_wptr == 3'(BB_RECORDS - 1)) ? 3'd0
                                                     : bb_wptr + 3'd1;
      if (bb_count < 3'(BB_RECORDS))
        next_bb_count = bb_count + 3'd1; // RL20
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt <= 32'd0;
      stamp    <= 16'h0000;
      bb_wptr  <= 3'd0;
      bb_count <= 3'd0;
    end else begin
      tick_cnt <= next_tick_cnt;
      stamp    <= next_stamp;
      bb_wptr  <= next_bb_wptr;
      bb_count <= next_bb_count;
    end
  end

  // record store, oldest slot overwritten once full
  always_ff @(posedge ref_clk) begin
    if (bb_trigger)
      bb_mem[bb_wptr] <= {stamp, bb_snapshot}; // RL20
  end

  a_unlock_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !unlocked |-> !erase_req && !mem_wr_valid && !app_start) // RL24
    else $error("upgrade action while locked");
  a_seq_advance: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (link_stop && phase == PH_WRITE && exec_ok && cmd == CMD_DATA &&
     idx == DATA_END + cnt && status[ST_BOOT] && data_ok)
    |=> exp_seq == $past(exp_seq) + 16'h0001) // RL8
    else $error("sequence did not advance by one");
  a_bad_pec_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (link_stop && phase == PH_WRITE && pec != 8'h00 && !erase_done)
    |=> $stable(exp_seq) && $stable(status)) // RL26
    else $error("state changed on bad pec");
  a_output_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
    sw_reboot && $past(main_output_on) |-> output_off) // RL4
    else $error("output left on in boot");
  a_erased_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
    erase_done && status[ST_BOOT] |=> status[ST_ERASED]) // RL6
    else $error("erase completion not flagged");
  a_exit_guard: assert property (@(posedge ref_clk) disable iff (!reset_n)
    app_start |-> $past(status) == STATUS_OK && status == STATUS_APP) // RL25
    else $error("application started with errors");
  a_seq_reply: assert property (@(posedge ref_clk) disable iff (!reset_n)
    link_rd_req && phase == PH_READ && cmd == CMD_DATA && rd_idx == 8'h01
    |=> tx_byte == $past(exp_seq[7:0])) // RL9
    else $error("sequence reply wrong");
  a_order_count: assert property (@(posedge ref_clk) disable iff (!reset_n)
    link_rd_req && phase == PH_READ && cmd == CMD_ORDER && rd_idx == 8'h00
    |=> tx_byte == ORDER_LEN) // RL18
    else $error("ordering code count wrong");
  a_bbox_empty: assert property (@(posedge ref_clk) disable iff (!reset_n)
    link_rd_req && phase == PH_READ && cmd == CMD_BBOX && rd_idx == 8'h00 &&
    !bb_data_ok |=> tx_byte == 8'h00) // RL22
    else $error("failed upload length not zero");
  a_bbox_depth: assert property (@(posedge ref_clk) disable iff (!reset_n)
    bb_trigger && bb_count == 3'(BB_RECORDS)
    |=> bb_count == 3'(BB_RECORDS) && bb_wptr != $past(bb_wptr)) // RL20
    else $error("recorder depth wrong");
endmodule

// file: bench/host_link_model.sv
// host controller model that drives the byte-level smbus link
// assumes the loader takes link pulses on the rising ref_clk edge
`timescale 1ns/100ps
module host_link_model (
  input  wire logic       ref_clk,
  output logic            link_start,
  output logic            link_stop,
  output logic            link_byte_valid,
  output logic      [7:0] link_byte,
  output logic            link_rd_req,
  input  wire logic [7:0] tx_byte
);
  localparam logic [7:0] ADDR_WR = 8'hB0;
  logic [7:0] rx_q[$];
  // link idles with every pulse low
  initial begin
    {link_start, link_stop, link_byte_valid, link_rd_req} = 4'h0;
    link_byte = 8'h00;
  end
  // crc-8 with poly 0x07 over every byte since the first start
  function automatic logic [7:0] pec8(input logic [7:0] q[$]);
    logic [7:0] c;
    c = 8'h00;
    foreach (q[i]) begin
      c = c ^ q[i];
      for (int b = 0; b < 8; b++) begin
        c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction
  // one link event held for one cycle, driven off the falling edge
  task automatic ev(input int k, input logic [7:0] b);
    @(negedge ref_clk);
    link_start      = (k == 0);
    link_byte_valid = (k == 1);
    link_rd_req     = (k == 2);
    link_stop       = (k == 3);
    link_byte       = b;
    @(negedge ref_clk);
    {link_start, link_stop, link_byte_valid, link_rd_req} = 4'h0;
    link_byte = ~b; // stale data never repeats the last byte
  endtask
  // write q with pec (bad flips its low bit) or write q then read nrd bytes
  task automatic txn(input logic [7:0] q[$], input int nrd,
                     input bit bad);
    logic [7:0] all[$];
    all  = {ADDR_WR, q};
    rx_q = {};
    ev(0, 8'h00);
    foreach (all[i]) ev(1, all[i]);
    if (nrd == 0) begin
      ev(1, pec8(all) ^ {7'h00, bad});
    end else begin
      ev(0, 8'h00);
      ev(1, ADDR_WR | 8'h01);
      repeat (nrd) begin
        ev(2, 8'h00);
        @(negedge ref_clk);
        rx_q.push_back(tx_byte);
      end
    end
    ev(3, 8'h00);
    repeat (3) @(negedge ref_clk); // short pause in sim
  endtask
endmodule

// file: bench/smbus_firmware_upgrade_loader_tb_top.sv
// self-checking bench for the firmware upgrade command interpreter
// assumes host_link_model drives the link; random data, fixed seed
`timescale 1ns/100ps
module smbus_firmware_upgrade_loader_tb_top;
  import fw_loader_pkg::*;
  logic ref_clk, reset_n, main_output_on, erase_done, output_off;
  logic sw_reboot, app_start, erase_req, mem_wr_valid, bb_trigger;
  logic bb_data_ok, link_start, link_stop, link_byte_valid, link_rd_req;
  logic [7:0] link_byte, tx_byte, erase_target, mem_wr_off;
  logic [7:0] mem_wr_data, app_status, tgt;
  logic [15:0] mem_wr_seq, c;
  logic [87:0] ordering_code;
  logic [31:0] bb_snapshot;
  logic [7:0] img[$], pq[$];
  logic [31:0] sq[$];
  int n_errors, num_checks, n_sw, n_app, n_er, n_wr;
  fw_upgrade_loader #(.TICK_CYCLES(4)) dut (.*);
  host_link_model host (.*);
  always #20 ref_clk = ~ref_clk;
  // count the one-cycle command pulses mid-cycle, where they stand
  always @(negedge ref_clk) begin
    if (sw_reboot === 1'b1) n_sw++;
    if (app_start === 1'b1) n_app++;
    if (erase_req === 1'b1) n_er++;
    if (mem_wr_valid === 1'b1) begin
      n_wr++;
      check8("wr_data", img[mem_wr_off], mem_wr_data);
      check8("wr_seq", 8'h00, mem_wr_seq[7:0] | mem_wr_seq[15:8]);
    end
  end
  task automatic check8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // image check value: crc-16 poly 0x1021, init all ones, msb first
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] r;
    r = CRC_INIT;
    foreach (q[i]) begin
      r = r ^ {q[i], 8'h00};
      for (int b = 0; b < 8; b++) begin
        r = r[15] ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog well past the expected run length
  initial begin
    #800000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    {ref_clk, reset_n, erase_done, bb_trigger} = 4'h0;
    {main_output_on, bb_data_ok} = 2'h3;
    bb_snapshot = 32'h00000000;
    void'($urandom(32'hEC72));
    ordering_code = 88'({$urandom(), $urandom(), $urandom()});
    tgt = 8'($urandom()); // one processor per upgrade pass
    repeat (5) @(negedge ref_clk);
    reset_n = 1'b1;
    host.txn({CMD_BOOT, tgt, ACT_ENTER}, 0, 0);
    check8("locked_reboots", 8'h00, 8'(n_sw));
    host.txn({CMD_UNLOCK, 8'h04, 8'h55, 8'h50, 8'h47, 8'h44}, 0, 0);
    host.txn({CMD_BOOT, tgt, ACT_ENTER}, 0, 0);
    check8("reboots", 8'h01, 8'(n_sw));
    check8("status", STATUS_OK, app_status);
    check8("output_off", 8'h01, 8'(output_off));
    host.txn({CMD_BOOT, tgt, ACT_ERASE}, 0, 1);
    check8("bad_pec_erases", 8'h00, 8'(n_er));
    host.txn({CMD_BOOT, tgt, ACT_ERASE}, 0, 0);
    check8("erases", 8'h01, 8'(n_er));
    check8("erase_target", tgt, erase_target);
    @(negedge ref_clk) erase_done = 1'b1;
    @(negedge ref_clk) erase_done = 1'b0;
    @(negedge ref_clk);
    check8("status", 8'h81, app_status);
    // one-packet image whose last two bytes carry its check value
    repeat (6) img.push_back(8'($urandom()));
    c = crc16(img);
    img.push_back(c[15:8]);
    img.push_back(c[7:0]);
    host.txn({CMD_DATA, tgt, 8'h00, 8'h00, 8'h08, img}, 0, 0);
    check8("payload_writes", 8'h08, 8'(n_wr));
    host.txn({CMD_DATA}, 4, 0);
    check8("seq_len", SEQ_LEN, host.rx_q[0]);
    check8("seq_lo", 8'h01, host.rx_q[1]);
    check8("seq_hi", 8'h00, host.rx_q[2]);
    check8("seq_status", 8'h81, host.rx_q[3]);
    host.txn({CMD_BOOT, tgt, ACT_DONE}, 0, 0);
    repeat (50) @(negedge ref_clk);
    check8("status", STATUS_OK, app_status);
    host.txn({CMD_BOOT, 8'h00, ACT_EXIT}, 0, 0);
    check8("app_starts", 8'h01, 8'(n_app));
    check8("status", STATUS_APP, app_status);
    // range, order and check errors must keep the application from starting
    main_output_on = 1'b0;
    host.txn({CMD_BOOT, tgt, ACT_ENTER}, 0, 0);
    check8("output_off", 8'h00, 8'(output_off));
    host.txn({CMD_BOOT, tgt, ACT_ERASE}, 0, 0);
    pq = {};
    repeat (33) pq.push_back(8'hA5);
    host.txn({CMD_DATA, tgt, 8'h00, 8'h00, 8'h21, pq}, 0, 0);
    check8("range_flag", 8'h08, app_status & 8'h08);
    host.txn({CMD_DATA, tgt, 8'h05, 8'h00, 8'h01, 8'hA5}, 0, 0);
    check8("seq_flag", 8'h04, app_status & 8'h04);
    host.txn({CMD_BOOT, tgt, ACT_DONE}, 0, 0);
    check8("crc_flag", 8'h02, app_status & 8'h02);
    host.txn({CMD_BOOT, tgt, ACT_EXIT}, 0, 0);
    check8("app_starts", 8'h01, 8'(n_app));
    host.txn({CMD_ORDER}, 13, 0);
    check8("order_len", ORDER_LEN, host.rx_q[0]);
    pq = {8'hB0, CMD_ORDER, 8'hB1, host.rx_q[0]};
    for (int k = 0; k < 11; k++) begin
      check8("order_byte", ordering_code[8*k +: 8], host.rx_q[k+1]);
      pq.push_back(host.rx_q[k+1]);
    end
    check8("order_pec", host.pec8(pq), host.rx_q[12]);
    // seven snapshots: the recorder keeps only the newest five
    repeat (7) begin
      @(negedge ref_clk);
      bb_snapshot = $urandom();
      sq.push_back(bb_snapshot);
      bb_trigger = 1'b1;
      @(negedge ref_clk) bb_trigger = 1'b0;
      repeat (8) @(negedge ref_clk);
    end
    host.txn({CMD_BBOX}, 31, 0);
    check8("bbox_len", 8'(BB_REC_BYTES * BB_RECORDS), host.rx_q[0]);
    // records come oldest first: snapshots two to six, low byte first
    for (int r = 0; r < BB_RECORDS; r++) begin
      for (int b = 0; b < 4; b++) begin
        check8("bbox_snap", sq[r+2][8*b +: 8], host.rx_q[1+6*r+b]);
      end
    end
    repeat (10) @(negedge ref_clk); // host pause before restart
    bb_data_ok = 1'b0;
    host.txn({CMD_BBOX}, 1, 0);
    check8("bbox_len", 8'h00, host.rx_q[0]);
    tally_and_finish();
  end
endmodule
